// >>> hw/tdac_pkg.sv
// Constants, types and helpers shared by the thermal code and analog input logic
// Functional notes
// RULE1: Offset code with bit 7 set means negative: temperature plus 128 in low bits.
// RULE2: Offset code with bit 7 clear is the zero-volt temperature in whole degrees.
// RULE3: 8-bit mode: code equals measured minus offset temperature, one degree per step.
// RULE4: 10-bit mode: each code step is a quarter degree above the offset temperature.
// RULE5: Code above DAC full scale saturates; default offset puts zero code at -40 degrees.
// RULE6: Reference select bit: clear picks internal 2.28 V, set picks supply voltage.
// RULE7: Two-bit field in configuration one makes shared pins analog inputs one and two.
// RULE8: Analog results are 10-bit straight binary, step is reference over 1024.
// RULE9: Code transitions sit midway between steps, first one at half a step.
// RULE10: Successive approximation: acquire, balance capacitor DAC, then flag done with code.
// RULE11: Select bits route internal to output A, external to B, refreshed each measurement.
// RULE12: Thermal resolution resets to 8-bit; a configuration three bit selects 10-bit.
// RULE13: Internal output zero-volt offset is an 8-bit register, one-degree resolution.
// RULE14: Measured temperature below offset clamps the thermal code at zero.
package tdac_pkg;
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned ACQ_TIME_NS = 500;
  localparam int unsigned ACQ_CYCLES = (ACQ_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned BIT_WAIT_CYCLES = 3;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_CFG1 = 8'h18;
  localparam logic [7:0] IDX_CFG3 = 8'h1A;
  localparam logic [7:0] IDX_INT_OFS = 8'h21;
  localparam logic [7:0] IDX_EXT_OFS = 8'h22;
  localparam logic [7:0] IDX_DAC_A = 8'h30;
  localparam logic [7:0] IDX_DAC_B = 8'h31;
  localparam logic [7:0] IDX_AIN_STAT = 8'h32;
  localparam logic [7:0] IDX_AIN_CTL = 8'h33;
  localparam int unsigned CFG1_ANALOG_INPUT_ONE_BIT = 1;
  localparam int unsigned CFG1_ANALOG_INPUT_TWO_BIT = 2;
  localparam int unsigned CFG3_RES_BIT = 1;
  localparam int unsigned CFG3_REF_BIT = 4;
  localparam int unsigned CFG3_INT_OUT_BIT = 5;
  localparam int unsigned CFG3_EXT_OUT_BIT = 6;
  localparam int unsigned CTL_START_BIT = 0;
  localparam int unsigned CTL_CHAN_LSB = 1;
  localparam int unsigned STAT_DONE_BIT = 14;
  localparam int unsigned STAT_BUSY_BIT = 15;
  localparam int unsigned OFS_NEG_BIT = 7;
  localparam logic [7:0] CFG1_RST = 8'h00;
  localparam logic [7:0] CFG3_RST = 8'h00;
  localparam logic [7:0] OFS_RST = 8'hD8;
  localparam logic [11:0] NEG_BIAS = 12'h080;
  localparam logic [9:0] DAC8_FULL = 10'h0FF;
  localparam logic [9:0] DAC10_FULL = 10'h3FF;

  typedef struct packed {
    logic busy;
    logic done;
    logic [9:0] code;
  } ain_result_t;

  typedef struct packed {
    logic res_10bit;
    logic [7:0] offset;
  } thermal_cfg_t;

  // Offset code to signed quarter degrees
  function automatic logic signed [11:0] offset_quarters(input logic [7:0] c);
    logic [11:0] deg;
    deg = 12'h000;
    // RULE1 negative offset
    if (c[OFS_NEG_BIT]) begin
      deg = {5'h00, c[6:0]} - NEG_BIAS;
    end else begin
      // RULE2 positive offset
      deg = {4'h0, c};
    end
    return signed'({deg[9:0], 2'b00});
  endfunction
endpackage

// >>> hw/thermal_code_calc.sv
// Turns a quarter-degree temperature and an offset code into a DAC code
`timescale 1ns/1ps
module thermal_code_calc (
  // Measurement and setup
  input wire logic [9:0] temp_q_in,
  input wire tdac_pkg::thermal_cfg_t cfg_in,
  // Result
  output logic [9:0] code_out
);
  import tdac_pkg::*;
  logic signed [11:0] diff;
  logic signed [11:0] deg;
  always_comb begin
    diff = signed'({{2{temp_q_in[9]}}, temp_q_in}) - offset_quarters(cfg_in.offset);
    deg = diff >>> 2;
    // RULE14 clamp below zero
    if (diff < 0) begin
      code_out = 10'h000;
    end else if (cfg_in.res_10bit) begin
      // RULE4 quarter degree steps
      code_out = (diff > signed'({2'b00, DAC10_FULL})) ? DAC10_FULL : diff[9:0];
    end else begin
      // RULE3 one degree steps, RULE5 saturate
      code_out = (deg > signed'({2'b00, DAC8_FULL})) ? DAC8_FULL : deg[9:0];
    end
  end
endmodule // thermal_code_calc

// >>> hw/sar_adc_ctrl.sv
// Successive approximation sequencer driving the capacitor DAC
`timescale 1ns/1ps
module sar_adc_ctrl #(
  parameter int unsigned ACQ = tdac_pkg::ACQ_CYCLES,
  parameter int unsigned WAIT = tdac_pkg::BIT_WAIT_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  // Control
  input wire logic start_in,
  input wire logic comp_in,
  // Status
  output logic sample_out,
  output logic [10:0] cap_dac_out,
  output tdac_pkg::ain_result_t result_out,
  output logic done_out
);
  import tdac_pkg::*;
  typedef enum logic [1:0] {S_IDLE, S_ACQ, S_BIT} sar_state_t;
  initial begin
    if (ACQ < 1 || ACQ > 255 || WAIT < 3 || WAIT > 255) $error("sar_adc_ctrl: bad timing");
  end
  sar_state_t state_reg, state_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [3:0] bit_reg, bit_next;
  logic [9:0] trial_reg, trial_next;
  logic [10:0] cap_reg, cap_next;
  logic sample_reg, sample_next, done_reg, done_next;
  ain_result_t res_reg, res_next;
  logic comp_meta_reg, comp_sync_reg;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      comp_meta_reg <= 1'b0;
      comp_sync_reg <= 1'b0;
    end else begin
      comp_meta_reg <= comp_in;
      comp_sync_reg <= comp_meta_reg;
    end
  end

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    bit_next = bit_reg;
    trial_next = trial_reg;
    sample_next = 1'b0;
    done_next = 1'b0;
    res_next = res_reg;
    case (state_reg)
      S_IDLE: begin
        if (start_in) begin
          state_next = S_ACQ;
          cnt_next = 8'(ACQ - 1);
          sample_next = 1'b1;
          res_next.busy = 1'b1;
          res_next.done = 1'b0;
        end
      end
      // RULE10 acquisition phase
      S_ACQ: begin
        sample_next = 1'b1;
        if (cnt_reg == 8'h00) begin
          sample_next = 1'b0;
          state_next = S_BIT;
          bit_next = 4'h9;
          trial_next = 10'h200;
          cnt_next = 8'(WAIT - 1);
        end else begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      // RULE10 balance one bit per trial
      S_BIT: begin
        if (cnt_reg != 8'h00) begin
          cnt_next = cnt_reg - 8'h01;
        end else begin
          if (!comp_sync_reg) begin
            trial_next[bit_reg] = 1'b0;
          end
          if (bit_reg == 4'h0) begin
            state_next = S_IDLE;
            done_next = 1'b1;
            res_next.busy = 1'b0;
            res_next.done = 1'b1;
            res_next.code = trial_next;
          end else begin
            bit_next = bit_reg - 4'h1;
            trial_next[bit_reg - 4'h1] = 1'b1;
            cnt_next = 8'(WAIT - 1);
          end
        end
      end
      default: state_next = S_IDLE;
    endcase
    // RULE9 taps shifted down half a step
    cap_next = (trial_next == 10'h000) ? 11'h000 : {trial_next, 1'b0} - 11'h001;
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_reg <= S_IDLE;
      cnt_reg <= 8'h00;
      bit_reg <= 4'h0;
      trial_reg <= 10'h000;
      cap_reg <= 11'h000;
      sample_reg <= 1'b0;
      done_reg <= 1'b0;
      res_reg <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      trial_reg <= trial_next;
      cap_reg <= cap_next;
      sample_reg <= sample_next;
      done_reg <= done_next;
      res_reg <= res_next;
    end
  end

  assign sample_out = sample_reg;
  assign cap_dac_out = cap_reg;
  assign result_out = res_reg;
  assign done_out = done_reg;

  // RULE10 sampling length
  acq_len_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // RULE10
    $rose(sample_reg) |-> sample_reg [*8])
    else $error("acquisition shorter than expected");
  // RULE9 half step tap
  half_tap_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // RULE9
    (state_reg == S_BIT && trial_reg != 10'h000) |-> cap_reg == {trial_reg, 1'b0} - 11'h001)
    else $error("cap DAC tap not half a step low");
  conv_cov: cover property (@(posedge sys_clk_in) disable iff (!arst_n_in) done_reg);
endmodule // sar_adc_ctrl

// >>> hw/thermal_dac_code_and_ain_setup.sv
// Thermal DAC code generation and analog input setup behind a Wishbone slave
`timescale 1ns/1ps
module thermal_dac_code_and_ain_setup (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic arst_n_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [9:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Temperature measurements, signed quarter degrees
  input wire logic int_temp_valid_in,
  input wire logic [9:0] int_temp_in,
  input wire logic ext_temp_valid_in,
  input wire logic [9:0] ext_temp_in,
  // Thermal DAC codes
  output logic [9:0] dac_a_code_out,
  output logic dac_a_load_out,
  output logic [9:0] dac_b_code_out,
  output logic dac_b_load_out,
  // Analog input converter
  input wire logic ain_comp_in,
  output logic ain_sample_out,
  output logic [10:0] ain_cap_dac_out,
  output logic [1:0] ain_channel_out,
  output logic ain_reference_select_out,
  output logic [1:0] shared_pin_input_select_out
);
  import tdac_pkg::*;

  logic [7:0] cfg1_reg, cfg1_next;
  logic [7:0] cfg3_reg, cfg3_next;
  logic [7:0] int_ofs_reg, int_ofs_next;
  logic [7:0] ext_ofs_reg, ext_ofs_next;
  logic [1:0] chan_reg, chan_next;
  logic start_reg, start_next;
  logic [31:0] rdata_reg, rdata_next;
  logic ack_reg, ack_next;
  logic [9:0] dac_a_reg, dac_a_next, dac_b_reg, dac_b_next;
  logic load_a_reg, load_a_next, load_b_reg, load_b_next;
  logic [9:0] code_a, code_b;
  logic [7:0] idx;
  logic req, wr;
  logic chan_ok;
  logic conv_done;
  ain_result_t ain_res;
  thermal_cfg_t cfg_a, cfg_b;

  assign idx = wb_adr_in[9:2];
  assign req = wb_cyc_in && wb_stb_in && !ack_reg;
  assign wr = req && wb_we_in && wb_sel_in[0];

  // RULE13 internal offset feeds output A
  assign cfg_a = '{res_10bit: cfg3_reg[CFG3_RES_BIT], offset: int_ofs_reg};
  assign cfg_b = '{res_10bit: cfg3_reg[CFG3_RES_BIT], offset: ext_ofs_reg};

  thermal_code_calc u_code_a (
    .temp_q_in(int_temp_in),
    .cfg_in(cfg_a),
    .code_out(code_a)
  );

  thermal_code_calc u_code_b (
    .temp_q_in(ext_temp_in),
    .cfg_in(cfg_b),
    .code_out(code_b)
  );

  sar_adc_ctrl #(
    .ACQ(ACQ_CYCLES),
    .WAIT(BIT_WAIT_CYCLES)
  ) u_sar (
    .sys_clk_in(sys_clk_in),
    .arst_n_in(arst_n_in),
    .start_in(start_reg),
    .comp_in(ain_comp_in),
    .sample_out(ain_sample_out),
    .cap_dac_out(ain_cap_dac_out),
    .result_out(ain_res),
    .done_out(conv_done)
  );

  // RULE7 shared pins must be analog inputs to convert them
  always_comb begin
    case (wb_dat_in[CTL_CHAN_LSB +: 2])
      2'd0: chan_ok = cfg1_reg[CFG1_ANALOG_INPUT_ONE_BIT];
      2'd1: chan_ok = cfg1_reg[CFG1_ANALOG_INPUT_TWO_BIT];
      default: chan_ok = 1'b1;
    endcase
  end

  // Register file and bus answer
  always_comb begin
    cfg1_next = cfg1_reg;
    cfg3_next = cfg3_reg;
    int_ofs_next = int_ofs_reg;
    ext_ofs_next = ext_ofs_reg;
    chan_next = chan_reg;
    start_next = 1'b0;
    ack_next = req;
    rdata_next = rdata_reg;
    if (wr) begin
      case (idx)
        IDX_CFG1: cfg1_next = wb_dat_in[7:0];
        // RULE12 resolution and RULE6 reference bits live here
        IDX_CFG3: cfg3_next = wb_dat_in[7:0];
        IDX_INT_OFS: int_ofs_next = wb_dat_in[7:0];
        IDX_EXT_OFS: ext_ofs_next = wb_dat_in[7:0];
        IDX_AIN_CTL: begin
          if (wb_dat_in[CTL_START_BIT] && chan_ok && !ain_res.busy) begin
            start_next = 1'b1;
            chan_next = wb_dat_in[CTL_CHAN_LSB +: 2];
          end
        end
        default: start_next = 1'b0;
      endcase
    end
    if (req && !wb_we_in) begin
      case (idx)
        IDX_CFG1: rdata_next = {24'h000000, cfg1_reg};
        IDX_CFG3: rdata_next = {24'h000000, cfg3_reg};
        IDX_INT_OFS: rdata_next = {24'h000000, int_ofs_reg};
        IDX_EXT_OFS: rdata_next = {24'h000000, ext_ofs_reg};
        IDX_DAC_A: rdata_next = {22'h000000, dac_a_reg};
        IDX_DAC_B: rdata_next = {22'h000000, dac_b_reg};
        // RULE8 straight binary result
        IDX_AIN_STAT: rdata_next = {16'h0000, ain_res.busy, ain_res.done, 4'h0, ain_res.code};
        IDX_AIN_CTL: rdata_next = {29'h00000000, chan_reg, 1'b0};
        default: rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg1_reg <= CFG1_RST;
      cfg3_reg <= CFG3_RST;
      int_ofs_reg <= OFS_RST;
      ext_ofs_reg <= OFS_RST;
      chan_reg <= 2'd0;
      start_reg <= 1'b0;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      cfg1_reg <= cfg1_next;
      cfg3_reg <= cfg3_next;
      int_ofs_reg <= int_ofs_next;
      ext_ofs_reg <= ext_ofs_next;
      chan_reg <= chan_next;
      start_reg <= start_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  // Thermal DAC refresh
  always_comb begin
    dac_a_next = dac_a_reg;
    dac_b_next = dac_b_reg;
    load_a_next = 1'b0;
    load_b_next = 1'b0;
    // RULE11 refresh on each measurement
    if (int_temp_valid_in && cfg3_reg[CFG3_INT_OUT_BIT]) begin
      dac_a_next = code_a;
      load_a_next = 1'b1;
    end
    if (ext_temp_valid_in && cfg3_reg[CFG3_EXT_OUT_BIT]) begin
      dac_b_next = code_b;
      load_b_next = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dac_a_reg <= 10'h000;
      dac_b_reg <= 10'h000;
      load_a_reg <= 1'b0;
      load_b_reg <= 1'b0;
    end else begin
      dac_a_reg <= dac_a_next;
      dac_b_reg <= dac_b_next;
      load_a_reg <= load_a_next;
      load_b_reg <= load_b_next;
    end
  end

  assign wb_ack_out = ack_reg;
  assign wb_dat_out = rdata_reg;
  assign dac_a_code_out = dac_a_reg;
  assign dac_a_load_out = load_a_reg;
  assign dac_b_code_out = dac_b_reg;
  assign dac_b_load_out = load_b_reg;
  assign ain_channel_out = chan_reg;
  // RULE6 reference source
  assign ain_reference_select_out = cfg3_reg[CFG3_REF_BIT];
  assign shared_pin_input_select_out = {cfg1_reg[CFG1_ANALOG_INPUT_TWO_BIT], cfg1_reg[CFG1_ANALOG_INPUT_ONE_BIT]};

  // Checks
  offset_neg_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // RULE1
    (int_temp_valid_in && cfg3_reg[CFG3_INT_OUT_BIT] && int_ofs_reg == 8'hD8 && !cfg3_reg[CFG3_RES_BIT]
     && int_temp_in == 10'h360) |=> dac_a_reg == 10'h000)
    else $error("minus 40 offset does not map minus 40 to zero");
  offset_pos_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // RULE2
    (int_temp_valid_in && cfg3_reg[CFG3_INT_OUT_BIT] && int_ofs_reg == 8'h0A && !cfg3_reg[CFG3_RES_BIT]
     && int_temp_in == 10'h050) |=> dac_a_reg == 10'h00A)
    else $error("positive offset misread");
  res8_range_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // RULE3
    (load_a_reg && !$past(cfg3_reg[CFG3_RES_BIT])) |-> dac_a_reg <= DAC8_FULL)
    else $error("8-bit code above full scale");
  res10_step_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // RULE4
    (int_temp_valid_in && cfg3_reg[CFG3_INT_OUT_BIT] && cfg3_reg[CFG3_RES_BIT] && int_ofs_reg == 8'hD8
     && int_temp_in == 10'h361) |=> dac_a_reg == 10'h001)
    else $error("10-bit step is not a quarter degree");
  floor_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // RULE14
    (int_temp_valid_in && cfg3_reg[CFG3_INT_OUT_BIT] && int_ofs_reg == 8'h0A
     && int_temp_in == 10'h3FC) |=> dac_a_reg == 10'h000)
    else $error("code wrapped below offset");
  refresh_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // RULE11
    (ext_temp_valid_in && cfg3_reg[CFG3_EXT_OUT_BIT]) |=> load_b_reg && dac_b_reg == $past(code_b))
    else $error("output B not refreshed");
  res_reset_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // RULE12
    $rose(arst_n_in) |-> !cfg3_reg[CFG3_RES_BIT])
    else $error("resolution not 8-bit after reset");
  ref_sel_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // RULE6
    (wr && idx == IDX_CFG3) |=> ain_reference_select_out == $past(wb_dat_in[CFG3_REF_BIT]))
    else $error("reference select does not follow its bit");
  pin_gate_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // RULE7
    start_reg && chan_reg == 2'd0 |-> cfg1_reg[CFG1_ANALOG_INPUT_ONE_BIT])
    else $error("conversion started on pin not set as input");
  done_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // RULE10
    start_reg |=> ain_res.busy ##[1:200] !ain_res.busy && ain_res.done)
    else $error("conversion did not finish");
  sat_a: assert property (@(posedge sys_clk_in) disable iff (!arst_n_in) // RULE5
    (int_temp_valid_in && cfg3_reg[CFG3_INT_OUT_BIT] && int_ofs_reg == 8'h80 && !cfg3_reg[CFG3_RES_BIT]
     && int_temp_in == 10'h1FF) |=> dac_a_reg == DAC8_FULL)
    else $error("top of range does not reach full scale");
  load_a_cov: cover property (@(posedge sys_clk_in) disable iff (!arst_n_in) load_a_reg);
  res10_cov: cover property (@(posedge sys_clk_in) disable iff (!arst_n_in) load_b_reg && cfg3_reg[CFG3_RES_BIT]);
  ain_cov: cover property (@(posedge sys_clk_in) disable iff (!arst_n_in) conv_done && chan_reg == 2'd1);
endmodule // thermal_dac_code_and_ain_setup

// >>> sim/testbench.sv
// Self-checking bench for the thermal DAC code and analog input setup block
`timescale 1ns/1ps
module testbench;
  import tdac_pkg::*;
  logic sys_clk_in, arst_n_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
  logic [9:0] wb_adr_in;
  logic [3:0] wb_sel_in;
  logic [31:0] wb_dat_in, wb_dat_out, rng_state, rdv;
  logic int_temp_valid_in, ext_temp_valid_in, dac_a_load_out, dac_b_load_out;
  logic [9:0] int_temp_in, ext_temp_in, dac_a_code_out, dac_b_code_out;
  logic ain_comp_in, ain_sample_out, ain_reference_select_out;
  logic [10:0] ain_cap_dac_out;
  logic [1:0] ain_channel_out, shared_pin_input_select_out;
  int err_count, check_count, cyc_count, vin_q;

  thermal_dac_code_and_ain_setup dut (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
    .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
    .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .int_temp_valid_in(int_temp_valid_in), .int_temp_in(int_temp_in),
    .ext_temp_valid_in(ext_temp_valid_in), .ext_temp_in(ext_temp_in),
    .dac_a_code_out(dac_a_code_out), .dac_a_load_out(dac_a_load_out),
    .dac_b_code_out(dac_b_code_out), .dac_b_load_out(dac_b_load_out),
    .ain_comp_in(ain_comp_in), .ain_sample_out(ain_sample_out), .ain_cap_dac_out(ain_cap_dac_out),
    .ain_channel_out(ain_channel_out), .ain_reference_select_out(ain_reference_select_out),
    .shared_pin_input_select_out(shared_pin_input_select_out)
  );

  // Analog input in quarter-LSB units, compared against the half-LSB tap
  assign ain_comp_in = (vin_q > 2 * int'(ain_cap_dac_out));

  always #2.5 sys_clk_in = ~sys_clk_in;

  always @(posedge sys_clk_in) begin
    cyc_count++;
    if (cyc_count >= 30000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  function automatic logic [31:0] next_rand();
    rng_state = rng_state ^ (rng_state << 13);
    rng_state = rng_state ^ (rng_state >> 17);
    rng_state = rng_state ^ (rng_state << 5);
    return rng_state;
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge sys_clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_adr_in <= {idx, 2'b00};
    wb_dat_in <= wd;
    do begin
      @(posedge sys_clk_in);
    end while (wb_ack_out !== 1'b1);
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    wb_we_in <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] x;
    wb(1'b1, idx, d, x);
    repeat (2) @(posedge sys_clk_in);
    #1;
  endtask

  task automatic rd_chk(input string name, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] x;
    wb(1'b0, idx, 32'h0, x);
    check(name, x, exp);
  endtask

  function automatic logic [9:0] exp_code(input logic [9:0] t, input logic [7:0] ofs, input logic res10);
    int oq, d;
    oq = ofs[7] ? (int'(ofs[6:0]) - 128) * 4 : int'(ofs) * 4;
    d = int'($signed(t)) - oq;
    if (d < 0) d = 0;
    if (!res10) d = d / 4;
    if (res10 && d > 1023) d = 1023;
    if (!res10 && d > 255) d = 255;
    return d[9:0];
  endfunction

  function automatic logic [9:0] exp_conv(input int q);
    int k;
    k = q / 4 + ((q % 4 == 3) ? 1 : 0);
    if (k > 1023) k = 1023;
    return k[9:0];
  endfunction

  task automatic temp_pulse(input logic [9:0] ti, input logic [9:0] te, input logic va, input logic vb);
    @(posedge sys_clk_in);
    int_temp_valid_in <= va;
    int_temp_in <= ti;
    ext_temp_valid_in <= vb;
    ext_temp_in <= te;
    @(posedge sys_clk_in);
    int_temp_valid_in <= 1'b0;
    ext_temp_valid_in <= 1'b0;
    #1;
  endtask

  task automatic conv(input logic [1:0] ch, input int q, input logic ok);
    int n;
    logic [31:0] x;
    vin_q = q;
    wr(IDX_AIN_CTL, 32'h1 | (32'(ch) << CTL_CHAN_LSB));
    wb(1'b0, IDX_AIN_STAT, 32'h0, x);
    check("ain busy", x[STAT_BUSY_BIT], ok);
    check("ain sampling", ain_sample_out, ok);
    if (ok) begin
      wr(IDX_AIN_CTL, 32'h1 | (32'h2 << CTL_CHAN_LSB));
      n = 0;
      do begin
        wb(1'b0, IDX_AIN_STAT, 32'h0, x);
        n++;
      end while (x[STAT_DONE_BIT] !== 1'b1 && n < 200);
      check("ain busy after done", x[STAT_BUSY_BIT], 1'b0);
      check("ain code", x[9:0], exp_conv(q));
      check("ain channel", ain_channel_out, ch);
    end
  endtask

  logic [7:0] ofs_tab [5] = '{8'hD8, 8'h80, 8'h0A, 8'h00, 8'h7F};
  logic [9:0] corner [7] = '{10'h360, 10'h1FF, 10'h200, 10'h000, 10'h050, 10'h361, 10'h3FC};
  logic [7:0] ofs, ofe;
  logic [9:0] ti, te;
  logic [31:0] tmp;

  initial begin
    sys_clk_in = 1'b0;
    arst_n_in = 1'b0;
    {wb_cyc_in, wb_stb_in, wb_we_in} = 3'b000;
    wb_adr_in = 10'h000;
    wb_sel_in = 4'h1;
    wb_dat_in = 32'h0;
    {int_temp_valid_in, ext_temp_valid_in} = 2'b00;
    int_temp_in = 10'h000;
    ext_temp_in = 10'h000;
    rng_state = 32'h0EE482BD;
    err_count = 0;
    check_count = 0;
    cyc_count = 0;
    vin_q = 0;
    repeat (8) @(posedge sys_clk_in);
    arst_n_in <= 1'b1;
    rd_chk("cfg1 reset", IDX_CFG1, 32'h0);
    rd_chk("cfg3 reset", IDX_CFG3, 32'h0);
    rd_chk("int offset reset", IDX_INT_OFS, 32'hD8);
    rd_chk("ext offset reset", IDX_EXT_OFS, 32'hD8);
    rd_chk("unmapped read", 8'h3F, 32'h0);
    check("pins reset", shared_pin_input_select_out, 2'b00);
    for (int r = 0; r < 2; r++) begin
      wr(IDX_CFG3, 32'h60 | (32'(r) << CFG3_RES_BIT) | (32'(r) << CFG3_REF_BIT));
      check("ref select", ain_reference_select_out, r[0]);
      for (int i = 0; i < 5; i++) begin
        ofs = ofs_tab[i];
        ofe = ofs_tab[(i + 2) % 5];
        wr(IDX_INT_OFS, 32'(ofs));
        wr(IDX_EXT_OFS, 32'(ofe));
        rd_chk("int offset", IDX_INT_OFS, 32'(ofs));
        for (int k = 0; k < 9; k++) begin
          tmp = next_rand();
          ti = (k < 7) ? corner[k] : tmp[9:0];
          te = tmp[25:16];
          temp_pulse(ti, te, 1'b1, 1'b1);
          check("dac a load", dac_a_load_out, 1'b1);
          check("dac a code", dac_a_code_out, exp_code(ti, ofs, r[0]));
          check("dac b load", dac_b_load_out, 1'b1);
          check("dac b code", dac_b_code_out, exp_code(te, ofe, r[0]));
        end
      end
    end
    wr(IDX_CFG3, 32'h20);
    temp_pulse(10'h100, 10'h100, 1'b0, 1'b1);
    check("dac b load refused", dac_b_load_out, 1'b0);
    check("dac a load idle", dac_a_load_out, 1'b0);
    wr(IDX_CFG1, 32'h02);
    check("pins one only", shared_pin_input_select_out, 2'b01);
    conv(2'd1, 5, 1'b0);
    conv(2'd0, 1, 1'b1);
    conv(2'd0, 3, 1'b1);
    wr(IDX_CFG1, 32'h06);
    check("pins both", shared_pin_input_select_out, 2'b11);
    conv(2'd1, 4095, 1'b1);
    for (int j = 0; j < 3; j++) begin
      tmp = next_rand();
      conv(tmp[1:0], 4 * int'(tmp[11:2]) + (tmp[12] ? 3 : 1), 1'b1);
    end
    wrap_up();
  end
endmodule // testbench
